// File: src/biv_pkg.sv
// Package for the board interrupt vectoring block: register map, reset
// values, opcode and field positions used by the device end and the bench.
// Assumes a single 10 MHz system clock on both ends.
package biv_pkg;
   localparam logic [7:0]  CALL_OPCODE   = 8'hCD;
   localparam int          NUM_IRQ       = 8;
   localparam int          NUM_VI        = 8;
   localparam int          NUM_EXT       = 3;
   localparam int          IRQ_SERIAL0   = 3;
   localparam int          IRQ_PRINTER   = 6;
   localparam int          IRQ_TIMED     = 7;
   // Register byte offsets on the APB side of the device end.
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_MASK      = 8'h04;
   localparam logic [7:0]  OFF_VIMAP     = 8'h08;
   localparam logic [7:0]  OFF_VBASE     = 8'h0C;
   localparam logic [7:0]  OFF_CASEN     = 8'h10;
   localparam logic [7:0]  OFF_STATUS    = 8'h14;
   // Control, vector map and status register fields.
   localparam int          CTRL_ENABLE   = 0;
   localparam int          CTRL_MASTER   = 1;
   localparam int          CTRL_SPACE8   = 2;
   localparam int          CTRL_OUTSEL   = 4;
   localparam int          CTRL_CASID    = 8;
   localparam int          VIMAP_EN      = 9;
   localparam int          STAT_PEND     = 8;
   localparam int          STAT_TPFLAG   = 16;
   localparam int          STAT_BUSY     = 17;
   // Values after reset, the own ROM address and the vector length.
   localparam logic [11:0] RST_CTRL      = 12'h000;
   localparam logic [7:0]  RST_MASK      = 8'hFF;
   localparam logic [11:0] RST_VIMAP     = 12'hE88;
   localparam logic [15:0] RST_VBASE     = 16'h0000;
   localparam logic [2:0]  RST_CASEN     = 3'h0;
   localparam logic [15:0] ROM_ADDR      = 16'hF000;
   localparam int          VEC_BYTES     = 3;
endpackage : biv_pkg

// File: src/biv_bus_if.sv
// Backplane bus between the interrupt controller board and the host CPU.
// The bench may drive vectored lines from other boards through viExtOe.
`timescale 1ns/100ps
`default_nettype none
interface biv_bus_if (
   input wire logic sysClk
);
   logic        pintOe;
   logic [7:0]  viOe;
   logic [7:0]  viExtOe;
   logic [7:0]  viLow;
   logic        pintLow;
   logic        inta;
   logic        rdStb;
   logic        ioRdClk;
   logic [7:0]  dataIn;
   logic        dataOe;
   logic        addrDisable;
   logic [15:0] romAddr;

   // Open-drain lines are low while any party enables its driver.
   assign pintLow = pintOe;
   assign viLow   = viOe | viExtOe;

   modport device (
      output pintOe, viOe, dataIn, dataOe, addrDisable, romAddr,
      input  viLow, inta, rdStb, ioRdClk
   );
   modport host (
      input  pintLow, dataIn, dataOe, addrDisable, romAddr,
      output inta, rdStb, ioRdClk
   );
endinterface : biv_bus_if
`default_nettype wire

// File: src/biv_device.sv
// Board interrupt controller end: synchronises the on-board sources, latches the timed pulse, routes
// vectored lines, raises PINT/ or a vectored line and answers the CALL
// acknowledge sequence as master or slave. Registers are on APB.
// Assumes the bus and APB share sys_clk; board source pins are async.
//
// Operation
// - Clock data port read clears timed request.
// - Timed pulse latched in a flip-flop.
// - Software programs level-triggered requests.
// - On-board sources fixed to inputs 3-7.
// - Serial 3-5, printer 6, timer 7.
// - Three vectored lines accepted as inputs.
// - Request drives PINT/ or chosen vectored line.
// - Cascade lines let master serve three slaves.
// - Master raises request and supplies CALL, address.
// - Slave requests master, supplies only address.
// - Unmasked valid request asserts interrupt output.
// - CPU acknowledges with INTA on next fetch.
// - Memory and others stay off during INTA.
// - Master drives CD on acknowledge read.
// - Next two reads carry the call address.
// - Master drives own ROM address three reads.
// - Address disable held while vector bytes flow.
// - Slave request routable to any vectored line.
// - External inputs default to lines 0,1,2.
// - Slave answers its own vectored request only when named on cascade.
// - Software may use transmit-empty for other intervals.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module biv_device (
   input  wire logic  sys_clk,
   input  wire logic  rstn,
   biv_bus_if.device  bus,
   input  wire logic  timedPulse,
   input  wire logic [2:0] serialReq,
   input  wire logic  wheelReady,
   input  wire logic [2:0] casIn,
   input  wire logic  casReqIn,
   output logic [2:0] casOut,
   output logic       casOe,
   input  wire logic  psel,
   input  wire logic  penable,
   input  wire logic  pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic       pready,
   output logic       pslverr
);
   typedef enum logic [1:0] {BIV_IDLE, BIV_LO, BIV_HI} biv_vec_t;

   logic [4:0]  syncA_ff, syncB_ff;
   logic        tpPrev_ff, tpFlag_ff;
   logic [11:0] ctrl_ff, viMap_ff;
   logic [7:0]  mask_ff, dataIn_ff;
   logic [15:0] vBase_ff, vecAddr_ff;
   logic [2:0]  casEn_ff;
   logic        dataOe_ff, addrDis_ff, ownAddr_ff, cascaded_ff;
   biv_vec_t    state_ff;
   logic [7:0]  irq, pending;
   logic [2:0]  level;
   logic        reqActive, isMaster, wr, rd, addrHit, casSel;

   function automatic logic [2:0] biv_prio(input logic [7:0] req);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = biv_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : biv_prio

   function automatic logic [15:0] biv_vec(input logic [15:0] base,
                                           input logic [2:0] lvl,
                                           input logic space8);
      return space8 ? base + {10'h000, lvl, 3'h0}
                    : base + {11'h000, lvl, 2'h0};
   endfunction : biv_vec

   // Board pins come from outside the clock domain.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         syncA_ff <= 5'h00;
         syncB_ff <= 5'h00;
      end else begin
         syncA_ff <= {timedPulse, wheelReady, serialReq};
         syncB_ff <= syncA_ff;
      end
   end

   // Timed request flag; a new edge in the clearing cycle wins.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tpPrev_ff <= 1'b0;
         tpFlag_ff <= 1'b0;
      end else begin
         tpPrev_ff <= syncB_ff[4];
         if (syncB_ff[4] && !tpPrev_ff) begin
            tpFlag_ff <= 1'b1;
         end else if (bus.ioRdClk) begin
            tpFlag_ff <= 1'b0;
         end
      end
   end

   // Request inputs: three routed vectored lines, then fixed sources.
   generate
      for (genvar g = 0; g < biv_pkg::NUM_EXT; g++) begin : g_ext
         assign irq[g] = viMap_ff[biv_pkg::VIMAP_EN + g]
                         && bus.viLow[viMap_ff[3*g +: 3]];
      end
   endgenerate
   assign irq[5:3] = syncB_ff[2:0];
   assign irq[6]   = syncB_ff[3];
   assign irq[7]   = tpFlag_ff;

   assign isMaster  = ctrl_ff[biv_pkg::CTRL_MASTER];
   assign pending   = irq & ~mask_ff;
   assign level     = biv_prio(pending);
   assign reqActive = ctrl_ff[biv_pkg::CTRL_ENABLE] && (|pending);
   // Request output to PINT/ as master or one vectored line as slave.
   assign bus.pintOe = reqActive && isMaster;
   always_comb begin
      bus.viOe = 8'h00;
      if (reqActive && !isMaster) begin
         bus.viOe[ctrl_ff[biv_pkg::CTRL_OUTSEL +: 3]] = 1'b1;
      end
   end
   // A slave is picked when the master names its id on the cascade.
   assign casSel = !isMaster && casReqIn
                   && (casIn == 3'({1'b0, ctrl_ff[biv_pkg::CTRL_CASID +: 2]}
                                   + 3'h1));

   // Vector sequence: opcode on the acknowledge, then two address reads.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff    <= BIV_IDLE;
         dataIn_ff   <= 8'h00;
         dataOe_ff   <= 1'b0;
         vecAddr_ff  <= 16'h0000;
         cascaded_ff <= 1'b0;
         ownAddr_ff  <= 1'b0;
      end else begin
         dataOe_ff <= 1'b0;
         case (state_ff)
            BIV_IDLE: begin
               if (bus.inta && bus.rdStb && isMaster && reqActive) begin
                  state_ff    <= BIV_LO;
                  dataIn_ff   <= biv_pkg::CALL_OPCODE;
                  dataOe_ff   <= 1'b1;
                  ownAddr_ff  <= 1'b1;
                  vecAddr_ff  <= biv_vec(vBase_ff, level,
                                         ctrl_ff[biv_pkg::CTRL_SPACE8]);
                  cascaded_ff <= level < 3'h3 && casEn_ff[level[1:0]];
               end else if (bus.inta && bus.rdStb && casSel) begin
                  state_ff    <= BIV_LO;
                  ownAddr_ff  <= 1'b0;
                  cascaded_ff <= 1'b0;
                  vecAddr_ff  <= biv_vec(vBase_ff, level,
                                         ctrl_ff[biv_pkg::CTRL_SPACE8]);
               end
            end
            BIV_LO: begin
               if (bus.rdStb) begin
                  state_ff  <= BIV_HI;
                  dataIn_ff <= vecAddr_ff[7:0];
                  dataOe_ff <= !cascaded_ff;
               end
            end
            BIV_HI: begin
               if (bus.rdStb) begin
                  state_ff  <= BIV_IDLE;
                  dataIn_ff <= vecAddr_ff[15:8];
                  dataOe_ff <= !cascaded_ff;
               end
            end
            default: state_ff <= BIV_IDLE;
         endcase
      end
   end

   // Address disable and the own ROM address cover all three reads.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addrDis_ff <= 1'b0;
      end else begin
         addrDis_ff <= (state_ff != BIV_IDLE) && ownAddr_ff
                       || (state_ff == BIV_IDLE && bus.inta && bus.rdStb
                           && isMaster && reqActive);
      end
   end
   assign bus.addrDisable = addrDis_ff;
   assign bus.romAddr     = addrDis_ff ? biv_pkg::ROM_ADDR
                                       : 16'h0000;
   assign bus.dataIn      = dataIn_ff;
   assign bus.dataOe      = dataOe_ff;
   // The master names a cascaded slave while that slave's bytes flow.
   assign casOe  = isMaster && cascaded_ff && state_ff != BIV_IDLE;
   // The code is the slave id plus one, so an idle cascade reads zero.
   assign casOut = casOe ? 3'({1'b0, level[1:0]} + 3'h1)
                         : 3'h0;

   // APB slave, zero wait states.
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign rd      = psel && !pwrite;
   assign addrHit = paddr inside {biv_pkg::OFF_CTRL, biv_pkg::OFF_MASK,
                                  biv_pkg::OFF_VIMAP, biv_pkg::OFF_VBASE,
                                  biv_pkg::OFF_CASEN, biv_pkg::OFF_STATUS};
   assign pslverr = psel && penable && !addrHit;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff  <= biv_pkg::RST_CTRL;
         mask_ff  <= biv_pkg::RST_MASK;
         viMap_ff <= biv_pkg::RST_VIMAP;
         vBase_ff <= biv_pkg::RST_VBASE;
         casEn_ff <= biv_pkg::RST_CASEN;
      end else if (wr) begin
         case (paddr)
            biv_pkg::OFF_CTRL:  ctrl_ff  <= pwdata[11:0];
            biv_pkg::OFF_MASK:  mask_ff  <= pwdata[7:0];
            biv_pkg::OFF_VIMAP: viMap_ff <= pwdata[11:0];
            biv_pkg::OFF_VBASE: vBase_ff <= pwdata[15:0];
            biv_pkg::OFF_CASEN: casEn_ff <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         case (paddr)
            biv_pkg::OFF_CTRL:   prdata <= {20'h00000, ctrl_ff};
            biv_pkg::OFF_MASK:   prdata <= {24'h000000, mask_ff};
            biv_pkg::OFF_VIMAP:  prdata <= {20'h00000, viMap_ff};
            biv_pkg::OFF_VBASE:  prdata <= {16'h0000, vBase_ff};
            biv_pkg::OFF_CASEN:  prdata <= {29'h00000000, casEn_ff};
            biv_pkg::OFF_STATUS: prdata <= {13'h0000, state_ff, tpFlag_ff,
                                            pending, irq};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : biv_device
`default_nettype wire

// File: src/biv_host.sv
// Host CPU end: reads the clock port on request and, while interrupts are
// enabled and PINT/ is low, runs the three-read CALL acknowledge sequence.
// Assumes the device answers each read with dataOe one cycle later.
`timescale 1ns/100ps
`default_nettype none
module biv_host (
   input  wire logic  sys_clk,
   input  wire logic  rstn,
   biv_bus_if.host    bus,
   input  wire logic  intEnable,
   input  wire logic  clockRdReq,
   output logic [7:0] opcode,
   output logic [15:0] callAddr,
   output logic       callDone,
   output logic       busy
);
   typedef enum logic [2:0] {BIVH_IDLE, BIVH_OP, BIVH_LO, BIVH_HI,
                             BIVH_WAIT} bivh_state_t;
   bivh_state_t state_ff;
   logic        issued_ff, ioRd_ff, done_ff;
   logic [7:0]  op_ff;
   logic [15:0] addr_ff;

   // One read strobe per byte; INTA only on the first.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= BIVH_IDLE;
         issued_ff <= 1'b0;
         op_ff     <= 8'h00;
         addr_ff   <= 16'h0000;
         done_ff   <= 1'b0;
      end else begin
         done_ff   <= 1'b0;
         issued_ff <= 1'b0;
         case (state_ff)
            BIVH_IDLE: begin
               if (intEnable && bus.pintLow) begin
                  state_ff  <= BIVH_OP;
                  issued_ff <= 1'b1;
               end
            end
            BIVH_OP: begin
               if (bus.dataOe) begin
                  op_ff     <= bus.dataIn;
                  state_ff  <= BIVH_LO;
                  issued_ff <= 1'b1;
               end
            end
            BIVH_LO: begin
               if (!issued_ff) begin
                  addr_ff[7:0] <= bus.dataIn;
                  state_ff     <= BIVH_HI;
                  issued_ff    <= 1'b1;
               end
            end
            BIVH_HI: begin
               if (!issued_ff) begin
                  addr_ff[15:8] <= bus.dataIn;
                  state_ff      <= BIVH_WAIT;
                  done_ff       <= 1'b1;
               end
            end
            BIVH_WAIT: state_ff <= BIVH_IDLE;
            default:   state_ff <= BIVH_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ioRd_ff <= 1'b0;
      end else begin
         ioRd_ff <= clockRdReq && state_ff == BIVH_IDLE;
      end
   end

   // No memory cycle runs under INTA, so only the device drives data.
   assign bus.inta    = issued_ff && state_ff == BIVH_OP;
   assign bus.rdStb   = issued_ff;
   assign bus.ioRdClk = ioRd_ff;
   assign opcode      = op_ff;
   assign callAddr    = addr_ff;
   assign callDone    = done_ff;
   assign busy        = state_ff != BIVH_IDLE;
endmodule : biv_host
`default_nettype wire

// File: test/biv_bus_chk.sv
// Checker for the backplane bus between the device end and the host end.
// Assumes both ends are design modules and that rstn is the shared reset.
`timescale 1ns/100ps
`default_nettype none
module biv_bus_chk (
   input wire logic        sysClk,
   input wire logic        rstn,
   input wire logic        pintOe,
   input wire logic        pintLow,
   input wire logic [7:0]  viOe,
   input wire logic        inta,
   input wire logic        rdStb,
   input wire logic [7:0]  dataIn,
   input wire logic        dataOe,
   input wire logic        addrDisable,
   input wire logic [15:0] romAddr
);
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (!rstn);

   AST_CALL_FIRST: assert property (
      inta && rdStb && pintLow |=> dataOe && dataIn == biv_pkg::CALL_OPCODE)
      else $error("first vector byte is not the call opcode");
   AST_ADIS_ON: assert property (
      inta && rdStb && pintLow |=> addrDisable)
      else $error("address disable missing after acknowledge");
   // Opcode plus two address bytes keep the address parked five cycles.
   AST_ADIS_HOLD: assert property (
      $rose(addrDisable) |-> addrDisable [*5])
      else $error("address disable dropped before the third read");
   AST_ROM_ADDR: assert property (
      addrDisable |-> romAddr == biv_pkg::ROM_ADDR)
      else $error("rom address not driven during vector");
   AST_ROM_IDLE: assert property (
      !addrDisable |-> romAddr == 16'h0000)
      else $error("rom address driven outside vector");
   AST_DATA_GATED: assert property (
      dataOe |-> addrDisable)
      else $error("vector byte without address disable");
   AST_ADDR_BYTE: assert property (
      rdStb && !inta && addrDisable |=> dataOe)
      else $error("address byte read got no data");
   AST_ONE_TARGET: assert property (
      pintOe |-> viOe == 8'h00)
      else $error("request drives both general and vectored lines");
   AST_VI_SINGLE: assert property (
      $onehot0(viOe))
      else $error("more than one vectored line driven");
endmodule : biv_bus_chk
`default_nettype wire

// File: test/board_interrupt_vectoring_tb.sv
// Testbench joining the device end and the host end over the bus.
// Assumes zero-wait APB and the host acknowledge walk of the device end.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin \
   check_count++; \
   if ((s) !== (e)) begin \
      mismatches++; \
      $display("CHECK FAILED %s expected %h seen %h", n, e, s); \
   end \
end
module board_interrupt_vectoring_tb;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        timedPulse = 1'b0;
   logic [2:0]  serialReq = 3'h0;
   logic        wheelReady = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        intEnable = 1'b0;
   logic        clockRdReq = 1'b0;
   logic [7:0]  opcode;
   logic [15:0] callAddr;
   logic        callDone;
   logic [31:0] expQ[$];
   logic [31:0] expv;
   logic [31:0] vb;
   logic [15:0] ea;
   int          check_count = 0;
   int          mismatches = 0;
   int          seed = 37;
   int          n;
   int          lvTab[6] = '{3, 4, 5, 6, 7, 1};

   always #50 sys_clk = ~sys_clk;

   biv_bus_if bus (.sysClk(sys_clk));
   initial bus.viExtOe = 8'h00;

   biv_device u_biv_device (.sys_clk(sys_clk), .rstn(rstn), .bus(bus),
      .timedPulse(timedPulse), .serialReq(serialReq), .wheelReady(wheelReady),
      .casIn(3'h0), .casReqIn(1'b0), .casOut(), .casOe(), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   biv_host u_biv_host (.sys_clk(sys_clk), .rstn(rstn), .bus(bus),
      .intEnable(intEnable), .clockRdReq(clockRdReq), .opcode(opcode),
      .callAddr(callAddr), .callDone(callDone), .busy());
   biv_bus_chk u_biv_bus_chk (.sysClk(sys_clk), .rstn(rstn),
      .pintOe(bus.pintOe), .pintLow(bus.pintLow), .viOe(bus.viOe),
      .inta(bus.inta), .rdStb(bus.rdStb), .dataIn(bus.dataIn),
      .dataOe(bus.dataOe), .addrDisable(bus.addrDisable),
      .romAddr(bus.romAddr));

   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // A read notes its expected word; the monitor compares it on the edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic err);
      if (!wr) expQ.push_back(d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : 32'h0;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      `CHK("pslverr", err, pslverr)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task src(input int k, input logic v);
      case (k)
         0, 1, 2: serialReq[k] <= v;
         3: wheelReady <= v;
         4: timedPulse <= v;
         default: bus.viExtOe[1] <= v;
      endcase
   endtask : src

   always @(posedge sys_clk) begin
      if (psel && penable && !pwrite && pready) begin
         expv = (expQ.size() > 0) ? expQ.pop_front() : 32'hDEAD_BEEF;
         `CHK("prdata", expv, prdata)
      end
      if (callDone === 1'b1) begin
         expv = (expQ.size() > 0) ? expQ.pop_front() : 32'hDEAD_BEEF;
         `CHK("call", expv, {8'h00, opcode, callAddr})
      end
   end

   initial begin
      #5_000_000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, biv_pkg::OFF_CTRL, {20'h0, biv_pkg::RST_CTRL}, 1'b0);
      apb(1'b0, biv_pkg::OFF_MASK, {24'h0, biv_pkg::RST_MASK}, 1'b0);
      apb(1'b0, biv_pkg::OFF_VIMAP, {20'h0, biv_pkg::RST_VIMAP},
          1'b0);
      apb(1'b0, biv_pkg::OFF_VBASE, {16'h0, biv_pkg::RST_VBASE}, 1'b0);
      apb(1'b0, biv_pkg::OFF_CASEN, {29'h0, biv_pkg::RST_CASEN}, 1'b0);
      apb(1'b1, 8'h18, 32'h1234_5678, 1'b1);
      apb(1'b0, 8'h18, 32'h0, 1'b1);
      $display("test registers done");
      for (int k = 0; k < 6; k++) begin
         vb = $random(seed) & 32'h0000_FFC0;
         ea = vb[15:0] + 16'(lvTab[k] * (k[0] ? 8 : 4));
         apb(1'b1, biv_pkg::OFF_VBASE, vb, 1'b0);
         apb(1'b1, biv_pkg::OFF_MASK, 32'hFF, 1'b0);
         apb(1'b1, biv_pkg::OFF_CTRL, 32'h3 | (32'(k[0]) << 2), 1'b0);
         src(k, 1'b1);
         repeat (4) @(posedge sys_clk);
         // The timed source is a short pulse; only the latch keeps it alive.
         if (k == 4) src(k, 1'b0);
         repeat (8) @(posedge sys_clk);
         `CHK("pintLow masked", 1'b0, bus.pintLow)
         apb(1'b1, biv_pkg::OFF_MASK, ~(32'h1 << lvTab[k]) & 32'hFF, 1'b0);
         expQ.push_back({8'h00, biv_pkg::CALL_OPCODE, ea});
         intEnable <= 1'b1;
         for (n = 0; n < 200 && bus.inta !== 1'b1; n++) @(posedge sys_clk);
         `CHK("inta", 1'b1, bus.inta)
         intEnable <= 1'b0;
         for (n = 0; n < 200 && callDone !== 1'b1; n++) @(posedge sys_clk);
         `CHK("callDone", 1'b1, callDone)
         if (k == 4) begin
            // Latched timed request still pending and unmasked.
            apb(1'b0, biv_pkg::OFF_STATUS,
                (32'h1 << biv_pkg::STAT_TPFLAG) | 32'h0000_8080,
                1'b0);
            clockRdReq <= 1'b1;
            @(posedge sys_clk);
            clockRdReq <= 1'b0;
            repeat (8) @(posedge sys_clk);
            `CHK("pintLow cleared", 1'b0, bus.pintLow)
         end else src(k, 1'b0);
         repeat (8) @(posedge sys_clk);
         $display("test call level %0d done", lvTab[k]);
      end
      apb(1'b1, biv_pkg::OFF_MASK, 32'hF7, 1'b0);
      apb(1'b1, biv_pkg::OFF_CTRL, 32'h51, 1'b0);
      src(0, 1'b1);
      repeat (8) @(posedge sys_clk);
      `CHK("viLow slave", 8'h20, bus.viLow)
      `CHK("pintLow slave", 1'b0, bus.pintLow)
      src(0, 1'b0);
      $display("test slave request done");
      tally_and_finish();
   end
endmodule : board_interrupt_vectoring_tb
`default_nettype wire
